// *** verilog/usb_port_fault_supervisor.sv ***
/*
 Control logic of a USB port protector: takes analog comparator flags and
 host enable inputs, drives power switches, data switches, fault output,
 autoreset and charger-detect controls.
 Assumes comparator flags and host pins are asynchronous and are
 synchronised here; analog loops act on the control levels driven out.
*/
`timescale 1ns/10ps
module usb_port_fault_supervisor
   import usb_guard_pkg::*;
#(
   parameter int unsigned PERSIST_CYCLES = PERSIST_CYC,
   parameter logic        ENABLE_HIGH    = ENABLE_ACT_HI
) (
   input  wire logic sys_clk,
   input  wire logic reset_n,
   input  wire logic enableIn,
   input  wire logic charger_detect_on,
   input  wire logic dataOverVolt,
   input  wire logic logicOverVolt,
   input  wire logic busOverVolt,
   input  wire logic busShortLow,
   input  wire logic busAboveHalfVolt,
   input  wire logic busOverCurrent,
   input  wire logic supplyUnderWarn,
   input  wire logic supplyUnderCrit,
   input  wire logic overTempHigh,
   input  wire logic overTempLow,
   input  wire logic limitSetLow,
   input  wire logic protectedLinesLow,
   output logic      ext_fet_gate,
   output logic      gateSlowRamp,
   output logic      intSwitchOn,
   output logic      dataSwitchOn,
   output logic      pulsedLimit,
   output logic      regulateLimit,
   output logic      reducedLimit,
   output logic      autoResetMode,
   output logic      overCurrentFlag,
   output logic      portDetectOn,
   output op_mode_t  opMode,
   output logic      faultOut,
   output logic      fault_n_oe_n
);
   typedef struct packed {
      logic [14:0] s1;
      logic [14:0] s2;
      logic        autoReset;
      logic        hotTrip;
      logic        rearmed;
      logic        gateSlow;
      logic        fetOn;
      logic        intOn;
      logic        dataOn;
      logic        detOn;
      logic        fault;
      logic        oc;
      logic        pulse;
      logic        reduce;
      op_mode_t    mode;
   } sup_state_t;

   sup_state_t st_reg;
   sup_state_t st_next;

   // Bit order of the synchronised inputs
   localparam int unsigned I_EN = 0, I_CH = 1, I_DOV = 2, I_LOV = 3, I_BOV = 4,
      I_SHT = 5, I_HALF = 6, I_OC = 7, I_UVW = 8, I_UVC = 9, I_THI = 10,
      I_TLO = 11, I_SET = 12, I_LLO = 13;

   logic [14:0] rawIn;
   logic [14:0] syn;
   logic        enActive;
   logic        ovAny;
   logic        uvWindow;
   logic        ovDone;
   logic        shortDone;
   logic        ocDone;
   logic        uvDone;
   logic        recoverDone;
   logic        rearmDone;
   logic        ocCond;

   assign rawIn = {1'b0, protectedLinesLow, limitSetLow, overTempLow, overTempHigh,
                   supplyUnderCrit, supplyUnderWarn, busOverCurrent, busAboveHalfVolt,
                   busShortLow, busOverVolt, logicOverVolt, dataOverVolt,
                   charger_detect_on, enableIn};
   assign syn = st_reg.s2;

   assign enActive = (syn[I_EN] == ENABLE_HIGH);
   assign ovAny    = syn[I_DOV] | syn[I_LOV] | syn[I_BOV];
   assign uvWindow = syn[I_UVW] & ~syn[I_UVC];
   assign ocCond   = syn[I_OC] & ~syn[I_SHT];

   persist_timer #(.LENGTH(PERSIST_CYCLES), .WIDTH(TIMER_W)) u_ov (
      .sys_clk(sys_clk), .reset_n(reset_n), .cond(ovAny), .done(ovDone));
   persist_timer #(.LENGTH(PERSIST_CYCLES), .WIDTH(TIMER_W)) u_short (
      .sys_clk(sys_clk), .reset_n(reset_n),
      .cond(syn[I_SHT] & ~st_reg.autoReset), .done(shortDone));
   persist_timer #(.LENGTH(PERSIST_CYCLES), .WIDTH(TIMER_W)) u_oc (
      .sys_clk(sys_clk), .reset_n(reset_n),
      .cond(ocCond & ~st_reg.autoReset), .done(ocDone));
   persist_timer #(.LENGTH(PERSIST_CYCLES), .WIDTH(TIMER_W)) u_uv (
      .sys_clk(sys_clk), .reset_n(reset_n), .cond(uvWindow), .done(uvDone));
   persist_timer #(.LENGTH(PERSIST_CYCLES), .WIDTH(TIMER_W)) u_rec (
      .sys_clk(sys_clk), .reset_n(reset_n),
      .cond(st_reg.autoReset & syn[I_HALF]), .done(recoverDone));
   persist_timer #(.LENGTH(REARM_CYC), .WIDTH(TIMER_W)) u_rearm (
      .sys_clk(sys_clk), .reset_n(reset_n), .cond(syn[I_LLO]), .done(rearmDone));

   always_comb begin
      st_next    = st_reg;
      st_next.s1 = rawIn;
      st_next.s2 = st_reg.s1;

      // Mode from host pins
      if (!enActive) begin
         st_next.mode = MODE_DISABLED;
      end else if (syn[I_CH]) begin
         st_next.mode = MODE_CHARGER;
      end else begin
         st_next.mode = MODE_HISPEED;
      end

      // Thermal trip with hysteresis
      if (syn[I_THI]) begin
         st_next.hotTrip = 1'b1;
      end else if (!syn[I_TLO]) begin
         st_next.hotTrip = 1'b0;
      end

      // Autoreset entry wins over recovery
      if (shortDone || ocDone) begin
         st_next.autoReset = 1'b1;
      end else if (recoverDone) begin
         st_next.autoReset = 1'b0;
      end

      st_next.pulse  = syn[I_SHT] & ~st_next.autoReset;
      st_next.oc     = ocCond;
      st_next.reduce = st_next.autoReset;

      // Re-arm detection after lines idle low
      if (!syn[I_LLO]) begin
         st_next.rearmed = 1'b0;
      end else if (rearmDone) begin
         st_next.rearmed = 1'b1;
      end

      st_next.fetOn  = enActive & ~ovAny & ~st_next.hotTrip & ~syn[I_SET]
                       & ~st_next.autoReset;
      st_next.intOn  = enActive & ~syn[I_UVW] & ~syn[I_UVC]
                       & ~st_next.hotTrip;
      st_next.dataOn = enActive & ~ovAny & ~syn[I_UVC] & ~st_next.hotTrip
                       & ~syn[I_SET];
      st_next.detOn  = enActive & syn[I_CH] & st_next.rearmed;

      if (st_reg.autoReset && !st_next.autoReset) begin
         st_next.gateSlow = 1'b1;
      end else if (st_next.autoReset || !st_next.fetOn) begin
         st_next.gateSlow = 1'b0;
      end

      st_next.fault = ovDone | uvDone | st_next.hotTrip | syn[I_SET]
                      | st_next.autoReset;

      // Gate, slow ramp, detection and fault held inactive on critical supply undervoltage
      if (syn[I_UVC]) begin
         st_next.fetOn    = 1'b0;
         st_next.detOn    = 1'b0;
         st_next.gateSlow = 1'b0;
         st_next.fault    = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign ext_fet_gate    = st_reg.fetOn;
   assign gateSlowRamp    = st_reg.gateSlow;
   assign intSwitchOn     = st_reg.intOn;
   assign dataSwitchOn    = st_reg.dataOn;
   assign pulsedLimit     = st_reg.pulse;
   assign regulateLimit   = st_reg.oc;
   assign reducedLimit    = st_reg.reduce;
   assign autoResetMode   = st_reg.autoReset;
   assign overCurrentFlag = st_reg.oc;
   assign portDetectOn    = st_reg.detOn;
   assign opMode          = st_reg.mode;
   assign faultOut        = st_reg.fault;
   assign fault_n_oe_n    = ~st_reg.fault;

   property p_ov_cut;
      @(posedge sys_clk) disable iff (!reset_n)
      ovAny |=> !ext_fet_gate && !dataSwitchOn;
   endproperty
   a_ov_cut: assert property (p_ov_cut) else $error("overvoltage left switches on");

   property p_ov_fault_late;
      @(posedge sys_clk) disable iff (!reset_n)
      $rose(ovAny) && !faultOut && !overTempHigh |=> !ovDone;
   endproperty
   a_ov_fault_late: assert property (p_ov_fault_late) else $error("early ov fault");

   property p_autoreset_limit;
      @(posedge sys_clk) disable iff (!reset_n)
      autoResetMode |-> reducedLimit && faultOut == !$past(syn[I_UVC]) && !ext_fet_gate;
   endproperty
   a_autoreset_limit: assert property (p_autoreset_limit) else $error("autoreset wrong");

   property p_short_entry;
      @(posedge sys_clk) disable iff (!reset_n)
      shortDone |=> autoResetMode;
   endproperty
   a_short_entry: assert property (p_short_entry) else $error("no autoreset");

   property p_recover;
      @(posedge sys_clk) disable iff (!reset_n)
      autoResetMode && recoverDone && !shortDone && !ocDone |=> !autoResetMode
      && gateSlowRamp == !$past(syn[I_UVC]);
   endproperty
   a_recover: assert property (p_recover) else $error("no recovery");

   property p_uv_int;
      @(posedge sys_clk) disable iff (!reset_n)
      syn[I_UVW] |=> !intSwitchOn;
   endproperty
   a_uv_int: assert property (p_uv_int) else $error("internal switch on in uv");

   property p_hot;
      @(posedge sys_clk) disable iff (!reset_n)
      syn[I_THI] && !syn[I_UVC] |=> faultOut && !ext_fet_gate && !intSwitchOn;
   endproperty
   a_hot: assert property (p_hot) else $error("overtemp not handled");

   property p_disabled;
      @(posedge sys_clk) disable iff (!reset_n)
      !enActive |=> !ext_fet_gate && !intSwitchOn && !dataSwitchOn && !portDetectOn;
   endproperty
   a_disabled: assert property (p_disabled) else $error("disabled yet switched");

   property p_fault_pin;
      @(posedge sys_clk) disable iff (!reset_n)
      fault_n_oe_n == !faultOut;
   endproperty
   a_fault_pin: assert property (p_fault_pin) else $error("fault pin mismatch");

   sequence s_short_fresh;
      syn[I_SHT] && !autoResetMode && !shortDone && !ocDone;
   endsequence

   property p_pulse;
      @(posedge sys_clk) disable iff (!reset_n)
      s_short_fresh |=> pulsedLimit;
   endproperty
   a_pulse: assert property (p_pulse) else $error("no pulsed limit on short");

   property p_oc_flag;
      @(posedge sys_clk) disable iff (!reset_n)
      overCurrentFlag == $past(ocCond) && regulateLimit == $past(ocCond);
   endproperty
   a_oc_flag: assert property (p_oc_flag) else $error("overcurrent flag wrong");

   sequence s_uv_persisted;
      uvDone && !syn[I_UVC];
   endsequence

   property p_uv_fault;
      @(posedge sys_clk) disable iff (!reset_n)
      s_uv_persisted |=> faultOut;
   endproperty
   a_uv_fault: assert property (p_uv_fault) else $error("no undervoltage fault");

   property p_crit;
      @(posedge sys_clk) disable iff (!reset_n)
      syn[I_UVC] |=> !ext_fet_gate && !intSwitchOn && !dataSwitchOn && !faultOut && !portDetectOn;
   endproperty
   a_crit: assert property (p_crit) else $error("logic active in critical uv");

   sequence s_hot_held;
      st_reg.hotTrip && syn[I_TLO] && !syn[I_UVC];
   endsequence

   property p_hot_hold;
      @(posedge sys_clk) disable iff (!reset_n)
      s_hot_held |=> faultOut;
   endproperty
   a_hot_hold: assert property (p_hot_hold) else $error("overtemp fault dropped early");

   property p_limit_set;
      @(posedge sys_clk) disable iff (!reset_n)
      syn[I_SET] && !syn[I_UVC] |=> faultOut && !ext_fet_gate && !dataSwitchOn;
   endproperty
   a_limit_set: assert property (p_limit_set) else $error("limit-set fault missed");

   sequence s_lines_busy;
      !syn[I_LLO];
   endsequence

   property p_rearm;
      @(posedge sys_clk) disable iff (!reset_n)
      s_lines_busy |=> (!portDetectOn) [*2];
   endproperty
   a_rearm: assert property (p_rearm) else $error("detection on with lines busy");
endmodule

// *** verilog/usb_guard_pkg.sv ***
/*
 Constants for the USB port fault supervisor: timer lengths at the
 40 MHz system clock, reset values and operating modes.
 Assumes a single 40 MHz clock domain.
*/
package usb_guard_pkg;
   localparam int unsigned CLK_HZ        = 40_000_000;
   localparam int unsigned PERSIST_MS    = 20;
   localparam int unsigned PERSIST_CYC   = PERSIST_MS * (CLK_HZ / 1000);
   localparam int unsigned REARM_US      = 100;
   localparam int unsigned REARM_CYC     = REARM_US * (CLK_HZ / 1_000_000) + 1;
   localparam int unsigned TIMER_W       = 20;
   localparam logic        FAULT_OE_RST  = 1'b1;
   localparam logic        ENABLE_ACT_HI = 1'b1;

   typedef enum logic [1:0] {
      MODE_DISABLED,
      MODE_HISPEED,
      MODE_CHARGER
   } op_mode_t;
endpackage

// *** verilog/persist_timer.sv ***
/*
 Persistence timer: reports done once cond has held without break for
 LENGTH clock cycles; any gap restarts it.
 Assumes cond is synchronous to sys_clk.
*/
`timescale 1ns/10ps
module persist_timer #(
   parameter int unsigned LENGTH = 800000,
   parameter int unsigned WIDTH  = 20
) (
   input  wire logic sys_clk,
   input  wire logic reset_n,
   input  wire logic cond,
   output logic      done
);
   typedef struct packed {
      logic [WIDTH-1:0] count;
      logic             done;
   } timer_state_t;

   timer_state_t st_reg;
   timer_state_t st_next;

   always_comb begin
      st_next = st_reg;
      if (!cond) begin
         st_next.count = '0;
         st_next.done  = 1'b0;
      end else if (!st_reg.done) begin
         if (st_reg.count == WIDTH'(LENGTH - 1)) begin
            st_next.done = 1'b1;
         end else begin
            st_next.count = st_reg.count + 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign done = st_reg.done;
endmodule

// *** test/usb_host_model.sv ***
/*
 Host pin model: turns a requested mode into enable and charger-detect
 levels in a legal order.
 Assumes the supervisor samples both pins on sys_clk.
*/
`timescale 1ns/10ps
module usb_host_model
   import usb_guard_pkg::*;
#(
   parameter logic ENABLE_HIGH = ENABLE_ACT_HI
) (
   input  wire logic     sys_clk,
   input  wire logic     reset_n,
   input  wire op_mode_t wantMode,
   output logic          enableIn,
   output logic          charger_detect_on
);
   logic enabled;

   // Pin level follows the variant's polarity
   assign enableIn = enabled ~^ ENABLE_HIGH;

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         enabled           <= 1'b0;
         charger_detect_on <= 1'b0;
      end else begin
         case (wantMode)
            MODE_HISPEED: begin
               charger_detect_on <= 1'b0;
               enabled           <= enabled | !charger_detect_on;
            end
            MODE_CHARGER: begin
               enabled           <= 1'b1;
               charger_detect_on <= 1'b1;
            end
            default: begin
               // Enable falls together with charger-detect
               enabled           <= 1'b0;
               charger_detect_on <= 1'b0;
            end
         endcase
      end
   end
endmodule

// *** test/usb_port_fault_supervisor_bench.sv ***
/*
 Self-checking bench for the USB port fault supervisor.
 Assumes a short persistence count; the host model drives the mode pins.
*/
`timescale 1ns/10ps
module usb_port_fault_supervisor_bench;
   import usb_guard_pkg::*;
   localparam int unsigned PER = 50;
   logic        sys_clk, reset_n, enableIn, charger_detect_on;
   logic [11:0] sense;
   logic        ext_fet_gate, gateSlowRamp, intSwitchOn, dataSwitchOn, pulsedLimit;
   logic        regulateLimit, reducedLimit, autoResetMode, overCurrentFlag, portDetectOn;
   logic        faultOut, fault_n_oe_n;
   op_mode_t    opMode, wantMode;
   int          failures, num_checks, seed, i, n;
   int          idx[7]  = '{0, 1, 2, 6, 7, 8, 10};
   int          kind[7] = '{1, 1, 1, 1, 0, 2, 2};

   usb_host_model i_usb_host_model (.sys_clk(sys_clk), .reset_n(reset_n),
      .wantMode(wantMode), .enableIn(enableIn), .charger_detect_on(charger_detect_on));

   usb_port_fault_supervisor #(.PERSIST_CYCLES(PER)) i_usb_port_fault_supervisor (
      .sys_clk(sys_clk), .reset_n(reset_n), .enableIn(enableIn),
      .charger_detect_on(charger_detect_on), .dataOverVolt(sense[0]),
      .logicOverVolt(sense[1]), .busOverVolt(sense[2]), .busShortLow(sense[3]),
      .busAboveHalfVolt(sense[4]), .busOverCurrent(sense[5]), .supplyUnderWarn(sense[6]),
      .supplyUnderCrit(sense[7]), .overTempHigh(sense[8]), .overTempLow(sense[9]),
      .limitSetLow(sense[10]), .protectedLinesLow(sense[11]), .ext_fet_gate(ext_fet_gate),
      .gateSlowRamp(gateSlowRamp), .intSwitchOn(intSwitchOn), .dataSwitchOn(dataSwitchOn),
      .pulsedLimit(pulsedLimit), .regulateLimit(regulateLimit), .reducedLimit(reducedLimit),
      .autoResetMode(autoResetMode), .overCurrentFlag(overCurrentFlag),
      .portDetectOn(portDetectOn), .opMode(opMode), .faultOut(faultOut),
      .fault_n_oe_n(fault_n_oe_n));

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   // Expected {fet, internal switch, data switches} for steady levels
   function automatic logic [2:0] expSw(op_mode_t m, logic [11:0] s);
      logic en;
      en = (m != MODE_DISABLED);
      return {en & ~(s[0] | s[1] | s[2] | s[7] | s[8] | s[10]),
              en & ~(s[6] | s[7] | s[8]),
              en & ~(s[0] | s[1] | s[2] | s[7] | s[8] | s[10])};
   endfunction

   task automatic tick(int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask

   task automatic check(string name, logic [2:0] seen, logic [2:0] exp);
      num_checks++;
      if (seen !== exp) begin
         $display("unexpected %s expected %0h seen %0h", name, exp, seen);
         failures++;
      end
   endtask

   task automatic checkFault(logic exp);
      check("faultOut", faultOut, exp);
      check("fault_n_oe_n", fault_n_oe_n, !exp);
   endtask

   task automatic restart(op_mode_t m);
      sense    = 12'h010;
      wantMode = m;
      reset_n  = 1'b0;
      tick(5);
      reset_n  = 1'b1;
      tick(8);
   endtask

   task automatic print_verdict();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      repeat (30000) @(posedge sys_clk);
      failures++;
      print_verdict();
   end

   initial begin
      failures = 0;
      num_checks = 0;
      seed = 32'h28e5f57d;
      restart(MODE_DISABLED);
      checkFault(1'b0);
      check("switches", {ext_fet_gate, intSwitchOn, dataSwitchOn}, 3'h0);
      check("opModeOff", opMode, MODE_DISABLED);
      wantMode = MODE_CHARGER;
      tick(8);
      sense[11] = 1'b1;
      check("opMode", opMode, MODE_CHARGER);
      tick(REARM_CYC - 20);
      check("portDetectEarly", portDetectOn, 1'b0);
      tick(30);
      check("portDetectOn", portDetectOn, 1'b1);
      wantMode = MODE_HISPEED;
      tick(8);
      check("opMode", opMode, MODE_HISPEED);
      check("portDetectOff", portDetectOn, 1'b0);
      for (i = 0; i < 7; i++) begin
         restart(MODE_HISPEED);
         check("switchesOn", {ext_fet_gate, intSwitchOn, dataSwitchOn}, 3'h7);
         sense[idx[i]] = 1'b1;
         sense[9] = sense[8];
         tick(4);
         check("switchesCut", {ext_fet_gate, intSwitchOn, dataSwitchOn},
               expSw(wantMode, sense));
         checkFault(kind[i] == 2);
         tick(PER - 8);
         checkFault(kind[i] == 2);
         tick(12);
         checkFault(kind[i] != 0);
         if (idx[i] == 8) begin
            sense[8] = 1'b0;
            tick(PER);
            checkFault(1'b1);
            sense[9] = 1'b0;
            tick(5);
            checkFault(1'b0);
         end
      end
      restart(MODE_HISPEED);
      repeat (4) begin
         sense[0] = 1'b1;
         n = 10 + ($unsigned($random(seed)) % (PER - 20));
         tick(n);
         sense[0] = 1'b0;
         tick(1 + ($unsigned($random(seed)) % 3));
         checkFault(1'b0);
      end
      sense[0] = 1'b1;
      tick(PER + 8);
      checkFault(1'b1);
      for (i = 0; i < 2; i++) begin
         restart(MODE_HISPEED);
         if (i == 0)
            sense[4:3] = 2'b01;
         else
            sense[5] = 1'b1;
         tick(4);
         check("pulsedLimit", pulsedLimit, i == 0);
         check("overCurrent", {overCurrentFlag, regulateLimit}, {2{i == 1}});
         tick(PER + 6);
         check("autoReset", {autoResetMode, reducedLimit, faultOut}, 3'h7);
         check("fetInAutoReset", ext_fet_gate, 1'b0);
         // Bus collapses below half a volt once, then recovers
         sense[5:3] = 3'b001;
         tick(1);
         sense[5:3] = 3'b010;
         tick(PER - 7);
         check("autoResetHeld", autoResetMode, 1'b1);
         tick(12);
         check("recovered", {autoResetMode, faultOut, gateSlowRamp}, 3'h1);
         check("fetRecovered", ext_fet_gate, 1'b1);
      end
      print_verdict();
   end
endmodule
